// file: core/deirq_edge.sv
// rising-edge detector used for the level that only counts on its rise
`timescale 1ns/100ps
module deirq_edge (
    input  wire logic clock_i,   // display clock
    input  wire logic srst_i,    // sync reset
    input  wire logic level_i,   // level input, same domain
    output logic      rise_o     // one-cycle pulse on rise
);
    logic prev_q;

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level_i;
        end
    end

    assign rise_o = level_i & ~prev_q;
endmodule

// file: core/deirq_pkg.sv
// package: register map and bit layout of the display interrupt unit
package deirq_pkg;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned ADDR_W       = 20;
    // register byte offsets
    localparam logic [19:0] OFF_LIVE     = 20'h44000;
    localparam logic [19:0] OFF_MASK     = 20'h44004;
    localparam logic [19:0] OFF_IDENTITY = 20'h44008;
    localparam logic [19:0] OFF_ENABLE   = 20'h4400c;
    // reset values
    localparam logic [31:0] RST_MASK     = 32'h0fffffff;
    localparam logic [31:0] RST_IDENTITY = 32'h00000000;
    localparam logic [31:0] RST_ENABLE   = 32'h00000000;
    // field positions
    localparam int unsigned BIT_MASTER   = 31;
    localparam int unsigned BIT_SOUTH    = 21;
    localparam int unsigned BIT_FAULT    = 24;
    // bits that carry a source (30 and 19 are reserved; 31 is master only)
    localparam logic [31:0] SRC_BITS     = 32'h3ff7ffff;
    // bus read latency in cycles
    localparam int unsigned RD_LAT       = 1;
endpackage

// file: core/deirq_top.sv
// display engine interrupt collector with live, mask, identity, enable
//
// Notes on behaviour
// RULE1: enable bit 31 is master gate; zero blocks the display interrupt.
// RULE2: cpu interrupt is OR of display, graphics and power identities.
// RULE3: bits 29..26 pulse on sprite B, sprite A, primary B, A flips.
// RULE4: bit 25 pulses on thermal/frequency event wire (earlier variant).
// RULE5: bit 24 is high while either translation fault bit is set.
// RULE6: bit 23 pulses when a poison message arrives.
// RULE7: bit 21 mirrors south display level; identity sets on rise only.
// RULE8: bit 20 pulses on aux channel A done.
// RULE9: bit 18 pulses on system level event (later variant).
// RULE10: bits 17 and 16 pulse on power-save histogram and phase-in.
// RULE11: pipe B: bit 15 during vblank, bit 11 during vsync.
// RULE12: pipe B: bit 14 even field, bit 13 odd field.
// RULE13: pipe B: bit 12 while scan line is in compare range.
// RULE14: pipe B: bit 10 crc done, 9 crc error, 8 underrun level.
// RULE15: pipe A: bit 7 during vblank, bit 3 during vsync.
// RULE16: pipe A: bits 6, 5 fields, bit 4 line compare.
// RULE17: pipe A: bit 2 crc done, 1 crc error, 0 underrun level.
// RULE18: live status reads current non-sticky source values.
// RULE19: mask one blocks recording; mask resets to 0fffffff.
// RULE20: unmasked event sets identity bit until software clears it.
// RULE21: software should not poll live status for short pulses.
// RULE22: writing one to identity bit clears it; zero leaves it.
// RULE23: disabled sources still record identity but raise no interrupt.
// RULE24: display irq is master and any enabled identity bit set.
`timescale 1ns/100ps
module deirq_top
    import deirq_pkg::*;
#(
    parameter bit EARLY_VARIANT = 1'b1   // 1: bit 25 thermal, 0: bit 18
) (
    input  wire logic              clock_i,          // display clock
    input  wire logic              srst_i,           // sync reset, high
    // register access
    input  wire logic [ADDR_W-1:0] reg_addr_i,       // byte address
    input  wire logic              reg_wr_i,         // write strobe
    input  wire logic              reg_rd_i,         // read strobe
    input  wire logic [DATA_W-1:0] reg_wdata_i,      // write data
    output logic [DATA_W-1:0]      reg_rdata_o,      // read data
    output logic                   reg_rvalid_o,     // read data valid
    // event sources, display clock domain
    input  wire logic [3:0]        flip_done_i,      // spr B,spr A,pri B,pri A
    input  wire logic              thermal_freq_event_i,  // pulse
    input  wire logic [1:0]        translation_fault_i,   // fault status bits
    input  wire logic              poison_i,         // pulse
    input  wire logic              perf_counter_i,   // pulse
    input  wire logic              aux_a_done_i,     // pulse
    input  wire logic              system_level_event_i,  // pulse
    input  wire logic              power_save_histogram_i, // pulse
    input  wire logic              power_save_phase_in_i,  // pulse
    input  wire logic [1:0]        pipe_vblank_i,    // [1]=B [0]=A level
    input  wire logic [1:0]        pipe_even_i,      // even field level
    input  wire logic [1:0]        pipe_odd_i,       // odd field level
    input  wire logic [1:0]        pipe_line_cmp_i,  // line compare level
    input  wire logic [1:0]        pipe_vsync_i,     // vsync level
    input  wire logic [1:0]        pipe_crc_done_i,  // crc done pulse
    input  wire logic [1:0]        pipe_crc_err_i,   // crc error pulse
    input  wire logic [1:0]        pipe_underrun_i,  // underrun level
    // south display interrupt arrives from another chip
    input  wire logic              south_display_irq_i, // async level
    // other engines
    input  wire logic              graphics_identity_vector_i, // any set
    input  wire logic              power_identity_vector_i,    // any set
    output logic                   display_irq_o,    // display-only irq
    output logic                   cpu_irq_o         // combined cpu irq
);
    logic [31:0] mask_q;
    logic [31:0] ident_q;
    logic [31:0] enable_q;
    logic [31:0] live;
    logic [31:0] record;
    logic        south_meta_q;
    logic        south_sync_q;
    logic        south_rise;
    logic        wr_mask;
    logic        wr_ident;
    logic        wr_enable;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [19:0]       off);
        return a == off;
    endfunction

    // south level crosses in from outside; two flops before any use
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            south_meta_q <= 1'b0;
            south_sync_q <= 1'b0;
        end else begin
            south_meta_q <= south_display_irq_i;
            south_sync_q <= south_meta_q;
        end
    end

    deirq_edge u_south_edge (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .level_i (south_sync_q),
        .rise_o  (south_rise)
    );

    // live source vector
    always_comb begin
        live         = '0;
        live[29:26]  = flip_done_i;                            // [RULE3]
        live[25]     = EARLY_VARIANT & thermal_freq_event_i;   // [RULE4]
        live[24]     = |translation_fault_i;                   // [RULE5]
        live[23]     = poison_i;                               // [RULE6]
        live[22]     = perf_counter_i;
        live[21]     = south_sync_q;                           // [RULE7]
        live[20]     = aux_a_done_i;                           // [RULE8]
        live[18]     = ~EARLY_VARIANT & system_level_event_i;  // [RULE9]
        live[17]     = power_save_histogram_i;                 // [RULE10]
        live[16]     = power_save_phase_in_i;                  // [RULE10]
        live[15]     = pipe_vblank_i[1];                       // [RULE11]
        live[11]     = pipe_vsync_i[1];                        // [RULE11]
        live[14]     = pipe_even_i[1];                         // [RULE12]
        live[13]     = pipe_odd_i[1];                          // [RULE12]
        live[12]     = pipe_line_cmp_i[1];                     // [RULE13]
        live[10]     = pipe_crc_done_i[1];                     // [RULE14]
        live[9]      = pipe_crc_err_i[1];                      // [RULE14]
        live[8]      = pipe_underrun_i[1];                     // [RULE14]
        live[7]      = pipe_vblank_i[0];                       // [RULE15]
        live[3]      = pipe_vsync_i[0];                        // [RULE15]
        live[6]      = pipe_even_i[0];                         // [RULE16]
        live[5]      = pipe_odd_i[0];                          // [RULE16]
        live[4]      = pipe_line_cmp_i[0];                     // [RULE16]
        live[2]      = pipe_crc_done_i[0];                     // [RULE17]
        live[1]      = pipe_crc_err_i[0];                      // [RULE17]
        live[0]      = pipe_underrun_i[0];                     // [RULE17]
    end

    // events that may be recorded: south counts on its rise only
    always_comb begin
        record          = live & ~mask_q & SRC_BITS;           // [RULE19]
        record[BIT_SOUTH] = south_rise & ~mask_q[BIT_SOUTH];   // [RULE7]
    end

    assign wr_mask   = reg_wr_i & hit(reg_addr_i, OFF_MASK);
    assign wr_ident  = reg_wr_i & hit(reg_addr_i, OFF_IDENTITY);
    assign wr_enable = reg_wr_i & hit(reg_addr_i, OFF_ENABLE);

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            mask_q <= RST_MASK;                                // [RULE19]
        end else if (wr_mask) begin
            mask_q <= reg_wdata_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            enable_q <= RST_ENABLE;
        end else if (wr_enable) begin
            enable_q <= reg_wdata_i;
        end
    end

    // sticky identity; a new event wins over a same-cycle clear
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ident_q <= RST_IDENTITY;
        end else begin
            ident_q <= ((wr_ident ? ident_q & ~reg_wdata_i : ident_q)
                        | record) & SRC_BITS;       // [RULE20] [RULE22]
        end
    end

    // disabled bits stay recorded but are kept off the output
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            display_irq_o <= 1'b0;
            cpu_irq_o     <= 1'b0;
        end else begin
            display_irq_o <= enable_q[BIT_MASTER] &
                             |(ident_q & enable_q & SRC_BITS);
                             // [RULE1] [RULE23] [RULE24]
            cpu_irq_o     <= (enable_q[BIT_MASTER] &
                              |(ident_q & enable_q & SRC_BITS)) |
                             graphics_identity_vector_i |
                             power_identity_vector_i;          // [RULE2]
        end
    end

    // reads: one cycle latency; unmapped addresses return zero
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            reg_rdata_o  <= '0;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (!reg_rd_i) begin
                reg_rdata_o <= '0;
            end else if (hit(reg_addr_i, OFF_LIVE)) begin
                reg_rdata_o <= live;                           // [RULE18]
            end else if (hit(reg_addr_i, OFF_MASK)) begin
                reg_rdata_o <= mask_q;
            end else if (hit(reg_addr_i, OFF_IDENTITY)) begin
                reg_rdata_o <= ident_q;
            end else if (hit(reg_addr_i, OFF_ENABLE)) begin
                reg_rdata_o <= enable_q;
            end else begin
                reg_rdata_o <= '0;
            end
        end
    end
endmodule

// file: tb/deirq_peer_model.sv
// peer model: other engines' identity summaries feeding the cpu interrupt
`timescale 1ns/100ps
module deirq_peer_model (
    input  wire logic       clock_i,    // display clock
    input  wire logic [1:0] req_i,      // [1] power, [0] graphics
    output logic            graphics_o, // graphics identity any set
    output logic            power_o     // power identity any set
);
    // engines' summaries follow req_i as a level, registered one cycle late
    always_ff @(posedge clock_i) begin
        graphics_o <= req_i[0];
        power_o    <= req_i[1];
    end
endmodule

// file: tb/deirq_top_monitor.sv
// checker: port-level assertions for the display interrupt collector
`timescale 1ns/100ps
module deirq_top_monitor
    import deirq_pkg::*;
(
    input wire logic              clock_i,      // clock
    input wire logic              srst_i,       // reset
    input wire logic [ADDR_W-1:0] reg_addr_i,   // address
    input wire logic              reg_wr_i,     // write
    input wire logic              reg_rd_i,     // read
    input wire logic [DATA_W-1:0] reg_wdata_i,  // write data
    input wire logic [DATA_W-1:0] reg_rdata_o,  // read data
    input wire logic              reg_rvalid_o, // read valid
    input wire logic [1:0]        translation_fault_i, // faults
    input wire logic [1:0]        pipe_vblank_i,       // vblank
    input wire logic [1:0]        pipe_underrun_i,     // underrun
    input wire logic              graphics_identity_vector_i, // gfx
    input wire logic              power_identity_vector_i,    // pm
    input wire logic              display_irq_o, // display irq
    input wire logic              cpu_irq_o      // cpu irq
);
    logic master_q;
    logic live_rd;
    assign live_rd = reg_rd_i && reg_addr_i == OFF_LIVE;
    // shadow of the master gate, same timing as the enable register
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            master_q <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == OFF_ENABLE) begin
            master_q <= reg_wdata_i[BIT_MASTER];
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered next cycle");
    master_gate_a: assert property (display_irq_o |->
        $past(master_q)) else $error("display irq without master gate");
    cpu_or_a: assert property (!$past(srst_i) |-> cpu_irq_o ==
        (display_irq_o || $past(graphics_identity_vector_i)
        || $past(power_identity_vector_i))) else $error("cpu irq not the OR");
    irq_drop_a: assert property (reg_wr_i
        && reg_addr_i == OFF_ENABLE && reg_wdata_i == '0
        |-> ##2 !display_irq_o)
        else $error("display irq kept with all enables off");
    irq_sticky_a: assert property (display_irq_o && !reg_wr_i
        && !$past(reg_wr_i) |=> display_irq_o)
        else $error("display irq fell without a write");
    fault_live_a: assert property (live_rd |=>
        reg_rdata_o[24] == ($past(translation_fault_i) != 2'b00))
        else $error("fault bit wrong in live status");
    vblank_live_a: assert property (live_rd |=>
        {reg_rdata_o[15], reg_rdata_o[7]} == $past(pipe_vblank_i))
        else $error("vblank bits wrong in live status");
    underrun_live_a: assert property (live_rd |=>
        {reg_rdata_o[8], reg_rdata_o[0]} == $past(pipe_underrun_i))
        else $error("underrun bits wrong in live status");
endmodule
bind deirq_top deirq_top_monitor u_mon (.clock_i(clock_i), .srst_i(srst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .translation_fault_i(translation_fault_i),
    .pipe_vblank_i(pipe_vblank_i), .pipe_underrun_i(pipe_underrun_i),
    .graphics_identity_vector_i(graphics_identity_vector_i),
    .power_identity_vector_i(power_identity_vector_i),
    .display_irq_o(display_irq_o), .cpu_irq_o(cpu_irq_o));

// file: tb/deirq_top_tb.sv
// testbench: random and directed checks of the display interrupt collector
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
$display("FAIL %s exp %h got %h", nm, e, g); end end
module deirq_top_tb;
    import deirq_pkg::*;
    logic        clock_i, srst_i, reg_wr_i, reg_rd_i, f1, gfx, pwr;
    logic        display_irq_o, cpu_irq_o, reg_rvalid_o;
    logic [1:0]  peer_req;
    logic [19:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, ev, lfsr, rdata_late;
    int          failures = 0, n_checks = 0, cyc = 0;
    deirq_peer_model peer (.clock_i(clock_i), .req_i(peer_req),
        .graphics_o(gfx), .power_o(pwr));
    deirq_top #(.EARLY_VARIANT(1'b1)) dut (
        .clock_i(clock_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .flip_done_i(ev[29:26]), .thermal_freq_event_i(ev[25]),
        .translation_fault_i({f1, ev[24]}), .poison_i(ev[23]),
        .perf_counter_i(ev[22]), .aux_a_done_i(ev[20]),
        .system_level_event_i(ev[18]), .power_save_histogram_i(ev[17]),
        .power_save_phase_in_i(ev[16]), .pipe_vblank_i({ev[15], ev[7]}),
        .pipe_even_i({ev[14], ev[6]}), .pipe_odd_i({ev[13], ev[5]}),
        .pipe_line_cmp_i({ev[12], ev[4]}), .pipe_vsync_i({ev[11], ev[3]}),
        .pipe_crc_done_i({ev[10], ev[2]}), .pipe_crc_err_i({ev[9], ev[1]}),
        .pipe_underrun_i({ev[8], ev[0]}), .south_display_irq_i(ev[21]),
        .graphics_identity_vector_i(gfx), .power_identity_vector_i(pwr),
        .display_irq_o(display_irq_o), .cpu_irq_o(cpu_irq_o));
    // later variant shares every input; only its live status is compared
    deirq_top #(.EARLY_VARIANT(1'b0)) dut_late (
        .clock_i(clock_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(rdata_late), .reg_rvalid_o(),
        .flip_done_i(ev[29:26]), .thermal_freq_event_i(ev[25]),
        .translation_fault_i({f1, ev[24]}), .poison_i(ev[23]),
        .perf_counter_i(ev[22]), .aux_a_done_i(ev[20]),
        .system_level_event_i(ev[18]), .power_save_histogram_i(ev[17]),
        .power_save_phase_in_i(ev[16]), .pipe_vblank_i({ev[15], ev[7]}),
        .pipe_even_i({ev[14], ev[6]}), .pipe_odd_i({ev[13], ev[5]}),
        .pipe_line_cmp_i({ev[12], ev[4]}), .pipe_vsync_i({ev[11], ev[3]}),
        .pipe_crc_done_i({ev[10], ev[2]}), .pipe_crc_err_i({ev[9], ev[1]}),
        .pipe_underrun_i({ev[8], ev[0]}), .south_display_irq_i(ev[21]),
        .graphics_identity_vector_i(gfx), .power_identity_vector_i(pwr),
        .display_irq_o(), .cpu_irq_o());
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // bit 18 quiet on the early variant, bit 25 on the later one
    function automatic logic [31:0] exp_live(input logic [31:0] e,
                                             input logic        f,
                                             input logic        early);
        return (e & SRC_BITS & ~(early ? 32'h00040000 : 32'h02000000))
            | ({31'h0, f} << BIT_FAULT);
    endfunction
    task automatic wr(input logic [19:0] a, input logic [31:0] d);
        @(negedge clock_i);
        {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
        @(negedge clock_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [19:0] a,
                       input logic [31:0] e);
        @(negedge clock_i);
        {reg_addr_i, reg_rd_i} = {a, 1'b1};
        @(negedge clock_i);
        reg_rd_i = 1'b0;
        `CHK(nm, e, reg_rdata_o)
        `CHK("rvalid", 1'b1, reg_rvalid_o)
    endtask
    task automatic irqc(input logic d, input logic c);
        repeat (2) @(negedge clock_i);
        `CHK("display_irq", d, display_irq_o)
        `CHK("cpu_irq", c, cpu_irq_o)
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        cyc++;
        if (cyc > 5000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        {srst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
        {ev, f1, peer_req} = '0;
        lfsr = 32'h00016596;
        srst_i = 1'b1;
        repeat (16) @(negedge clock_i);
        srst_i = 1'b0;
        rdc("mask_rst", OFF_MASK, RST_MASK);
        rdc("ident_rst", OFF_IDENTITY, RST_IDENTITY);
        rdc("unmapped", 20'h44010, 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 12; i++) begin
            lfsr = nxt(lfsr);
            ev = (i == 0) ? SRC_BITS : lfsr & SRC_BITS;
            f1 = lfsr[30];
            repeat (3) @(negedge clock_i);
            rdc("live", OFF_LIVE, exp_live(ev, f1, 1'b1));
            `CHK("live_late", exp_live(ev, f1, 1'b0), rdata_late)
        end
        {ev, f1} = '0;
        $display("test live status done");
        wr(OFF_MASK, 32'h0);
        wr(OFF_IDENTITY, 32'hffffffff);
        rdc("ident_clr", OFF_IDENTITY, 32'h0);
        @(negedge clock_i) ev = 32'h04000000;
        @(negedge clock_i) ev = 32'h0;
        wr(OFF_ENABLE, 32'h04000000);
        irqc(1'b0, 1'b0);
        rdc("ident_set", OFF_IDENTITY, 32'h04000000);
        wr(OFF_ENABLE, 32'h84000000);
        irqc(1'b1, 1'b1);
        wr(OFF_IDENTITY, 32'h0);
        rdc("ident_w0", OFF_IDENTITY, 32'h04000000);
        wr(OFF_ENABLE, 32'h0);
        irqc(1'b0, 1'b0);
        wr(OFF_ENABLE, 32'h84000000);
        irqc(1'b1, 1'b1);
        wr(OFF_IDENTITY, 32'h04000000);
        irqc(1'b0, 1'b0);
        $display("test sticky identity done");
        wr(OFF_MASK, 32'hffffffff);
        @(negedge clock_i) ev = SRC_BITS;
        @(negedge clock_i) ev = 32'h0;
        rdc("masked", OFF_IDENTITY, 32'h0);
        wr(OFF_MASK, ~32'h00200000);
        for (int k = 0; k < 3; k++) begin
            // pass 0 keeps the level high after the clear: pass 1 sees no new record
            @(negedge clock_i) ev[21] = 1'b1;
            repeat (4) @(negedge clock_i);
            rdc("south", OFF_IDENTITY, {10'h0, k != 1, 21'h0});
            wr(OFF_IDENTITY, 32'h00200000);
            @(negedge clock_i) ev[21] = (k == 0);
        end
        $display("test mask and south edge done");
        for (int p = 1; p < 4; p++) begin
            @(negedge clock_i) peer_req = 2'(p);
            irqc(1'b0, 1'b1);
        end
        peer_req = 2'b00;
        irqc(1'b0, 1'b0);
        $display("test cpu combine done");
        conclude();
    end
endmodule
